/* src/dswsp_pkg.sv */
package dswsp_pkg;
  // ==========================================
  // timing and widths
  localparam int unsigned BIT_CYCLES     = 16;
  localparam int unsigned TIMEOUT_CYCLES = 512;
  localparam int unsigned SAMPLE_POINT   = 10;
  localparam int unsigned DRIVE_LOW_END  = 13;
  localparam int unsigned SPEEDUP_END    = 14;
  localparam int unsigned DATA_WIDTH     = 8;
  localparam int unsigned MODE_WIDTH     = 2;

  // ==========================================
  // reset values and mode codes
  localparam logic [1:0] MODE_SPECIAL_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SPECIAL_OTHER  = 2'h1;
  localparam logic [1:0] MODE_NORMAL         = 2'h2;
  localparam logic       CLKSEL_RESET        = 1'h0;

  typedef enum logic [3:0] {
    DSWSP_IDLE  = 4'h1,
    DSWSP_RX    = 4'h2,
    DSWSP_TX    = 4'h4,
    DSWSP_WAIT  = 4'h8
  } dswsp_state_t;
endpackage

/* src/dswsp_sync.sv */
module dswsp_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  // ==========================================
  // two-stage synchroniser, resets to idle-high
  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb
  begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= 1'h1;
      dout   <= 1'h1;
    end
    else
    begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule

/* src/debug_single_wire_serial_port.sv */
module debug_single_wire_serial_port
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       alt_clk_tick,
  input  wire logic       target_clock_select,
  input  wire logic       debug_serial_pin_in,
  output logic            debug_serial_pin_out,
  output logic            debug_serial_pin_oe,
  output logic            pull_up_enable,
  input  wire logic       mode_select_b,
  input  wire logic       mode_select_a,
  output logic [1:0]      op_mode,
  output logic            mode_select_c,
  output logic            debug_active,
  input  wire logic       activate_cmd,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_load,
  output logic            tx_busy,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            timeout
);
  // ==========================================
  // pin synchronisers
  logic pin_s;
  logic mb_s;
  logic ma_s;

  dswsp_sync u_sync_pin (.clk(clk), .reset(reset), .din(debug_serial_pin_in), .dout(pin_s));
  dswsp_sync u_sync_mb  (.clk(clk), .reset(reset), .din(mode_select_b),       .dout(mb_s));
  dswsp_sync u_sync_ma  (.clk(clk), .reset(reset), .din(mode_select_a),       .dout(ma_s));

  // ==========================================
  // mode capture once the synchronisers carry the straps
  // synchronisers sit at idle-high in reset, so wait two edges for them to fill
  logic       captured;
  logic       next_captured;
  logic [1:0] warm;
  logic [1:0] next_warm;
  logic [1:0] next_op_mode;
  logic       next_mode_c;
  logic       next_debug_active;

  always_comb
  begin
    next_warm         = {warm[0], 1'h1};
    next_captured     = captured | warm[1];
    next_op_mode      = op_mode;
    next_mode_c       = mode_select_c;
    next_debug_active = debug_active | activate_cmd;
    if (!captured && warm[1])
    begin
      next_mode_c = pin_s;
      if (!pin_s && !mb_s && !ma_s)
      begin
        next_op_mode      = dswsp_pkg::MODE_SPECIAL_SINGLE;
        next_debug_active = 1'h1;
      end
      else if (!pin_s)
        next_op_mode = dswsp_pkg::MODE_SPECIAL_OTHER;
      else
        next_op_mode = dswsp_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      captured      <= 1'h0;
      warm          <= 2'h0;
      op_mode       <= dswsp_pkg::MODE_NORMAL;
      mode_select_c <= 1'h1;
      debug_active  <= 1'h0;
    end
    else
    begin
      captured      <= next_captured;
      warm          <= next_warm;
      op_mode       <= next_op_mode;
      mode_select_c <= next_mode_c;
      debug_active  <= next_debug_active;
    end
  end

  // ==========================================
  // serial engine
  dswsp_pkg::dswsp_state_t state;
  dswsp_pkg::dswsp_state_t next_state;
  logic       pin_d;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [9:0] idle_cnt;
  logic [9:0] next_idle_cnt;
  logic [3:0] bits_left;
  logic [3:0] next_bits_left;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] next_rx_data;
  logic       next_rx_valid;
  logic       next_timeout;
  logic       next_pin_out;
  logic       next_pin_oe;
  logic       tick;
  logic       fall;

  // target clock is bus clock or an alternate clock tick
  assign tick = target_clock_select ? alt_clk_tick : 1'h1;
  assign fall = pin_d & ~pin_s & captured;

  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_idle_cnt  = idle_cnt;
    next_bits_left = bits_left;
    next_shreg     = shreg;
    next_rx_data   = rx_data;
    next_rx_valid  = 1'h0;
    next_timeout   = 1'h0;
    next_pin_out   = 1'h0;
    next_pin_oe    = 1'h0;
    if (fall)
      next_idle_cnt = 10'h000;
    else if (tick && state != dswsp_pkg::DSWSP_IDLE)
      next_idle_cnt = idle_cnt + 10'h001;
    if (tick && bit_cnt != 5'h1F)
      next_bit_cnt = bit_cnt + 5'h01;
    case (state)
      dswsp_pkg::DSWSP_IDLE:
      begin
        if (tx_load)
        begin
          next_shreg     = tx_data;
          next_bits_left = 4'(dswsp_pkg::DATA_WIDTH);
          next_state     = dswsp_pkg::DSWSP_TX;
          next_idle_cnt  = 10'h000;
        end
        else if (fall && debug_active)
        begin
          next_bits_left = 4'(dswsp_pkg::DATA_WIDTH);
          next_bit_cnt   = 5'h00;
          next_state     = dswsp_pkg::DSWSP_RX;
          next_idle_cnt  = 10'h000;
        end
      end
      dswsp_pkg::DSWSP_RX:
      begin
        if (fall)
          next_bit_cnt = 5'h00;
        if (tick && bit_cnt == 5'(dswsp_pkg::SAMPLE_POINT))
        begin
          next_shreg     = {shreg[6:0], pin_s};
          next_bits_left = bits_left - 4'h1;
          if (bits_left == 4'h1)
          begin
            next_rx_data  = {shreg[6:0], pin_s};
            next_rx_valid = 1'h1;
            next_state    = dswsp_pkg::DSWSP_IDLE;
          end
        end
      end
      dswsp_pkg::DSWSP_TX:
      begin
        if (fall)
          next_bit_cnt = 5'h00;
        if (bit_cnt < 5'(dswsp_pkg::DRIVE_LOW_END) && !shreg[7])
          next_pin_oe = 1'h1;
        // one-cycle speedup ends every bit, also the return after our own low
        else if (bit_cnt == 5'(dswsp_pkg::DRIVE_LOW_END) && tick)
        begin
          next_pin_oe  = 1'h1;
          next_pin_out = 1'h1;
        end
        if (tick && bit_cnt == 5'(dswsp_pkg::BIT_CYCLES - 1))
        begin
          next_shreg     = {shreg[6:0], 1'h0};
          next_bits_left = bits_left - 4'h1;
          next_bit_cnt   = 5'h1F;
          if (bits_left == 4'h1)
            next_state = dswsp_pkg::DSWSP_IDLE;
        end
      end
      default:
        next_state = dswsp_pkg::DSWSP_IDLE;
    endcase
    if (tick && idle_cnt == 10'(dswsp_pkg::TIMEOUT_CYCLES - 1) && !fall)
    begin
      next_timeout   = 1'h1;
      next_state     = dswsp_pkg::DSWSP_IDLE;
      next_bits_left = 4'h0;
      next_shreg     = 8'h00;
      next_idle_cnt  = 10'h000;
      next_bit_cnt   = 5'h1F;
      next_pin_oe    = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state                <= dswsp_pkg::DSWSP_IDLE;
      pin_d                <= 1'h1;
      bit_cnt              <= 5'h1F;
      idle_cnt             <= 10'h000;
      bits_left            <= 4'h0;
      shreg                <= 8'h00;
      rx_data              <= 8'h00;
      rx_valid             <= 1'h0;
      timeout              <= 1'h0;
      debug_serial_pin_out <= 1'h0;
      debug_serial_pin_oe  <= 1'h0;
      pull_up_enable       <= 1'h1;
      tx_busy              <= 1'h0;
    end
    else
    begin
      state                <= next_state;
      pin_d                <= pin_s;
      bit_cnt              <= next_bit_cnt;
      idle_cnt             <= next_idle_cnt;
      bits_left            <= next_bits_left;
      shreg                <= next_shreg;
      rx_data              <= next_rx_data;
      rx_valid             <= next_rx_valid;
      timeout              <= next_timeout;
      debug_serial_pin_out <= next_pin_out;
      debug_serial_pin_oe  <= next_pin_oe;
      pull_up_enable       <= 1'h1;
      tx_busy              <= (next_state == dswsp_pkg::DSWSP_TX);
    end
  end

  // ==========================================
  // checks
  chk_pullup_always: assert property (@(posedge clk) disable iff (reset)
    pull_up_enable) else $error("pull-up off");
  chk_low_not_high: assert property (@(posedge clk) disable iff (reset)
    debug_serial_pin_oe && !debug_serial_pin_out |-> state == dswsp_pkg::DSWSP_TX)
    else $error("low drive outside tx");
  chk_timeout_idle: assert property (@(posedge clk) disable iff (reset)
    timeout |-> state == dswsp_pkg::DSWSP_IDLE && bits_left == 4'h0)
    else $error("timeout left state");
  chk_timeout_count: assert property (@(posedge clk) disable iff (reset)
    timeout |-> $past(idle_cnt) == 10'(dswsp_pkg::TIMEOUT_CYCLES - 1))
    else $error("timeout early");
  chk_mode_special: assert property (@(posedge clk) disable iff (reset)
    captured && op_mode == dswsp_pkg::MODE_SPECIAL_SINGLE |-> debug_active)
    else $error("special mode without debug");
  chk_fall_restart: assert property (@(posedge clk) disable iff (reset)
    fall && state == dswsp_pkg::DSWSP_RX |=> bit_cnt == 5'h00)
    else $error("bit timer not restarted");
  chk_speedup_short: assert property (@(posedge clk) disable iff (reset)
    debug_serial_pin_out |=> !debug_serial_pin_out)
    else $error("speedup too long");
  chk_mode_stable: assert property (@(posedge clk) disable iff (reset)
    captured && $past(captured) |-> $stable(op_mode))
    else $error("mode changed after reset");
  cov_rx_byte: cover property (@(posedge clk) disable iff (reset) rx_valid);
  cov_timeout: cover property (@(posedge clk) disable iff (reset) timeout);
  cov_speedup: cover property (@(posedge clk) disable iff (reset) debug_serial_pin_out);
  cov_tx_byte: cover property (@(posedge clk) disable iff (reset) $fell(tx_busy));
endmodule

/* bench/dswsp_host.sv */
module dswsp_host
(
  input  wire logic clk,
  input  wire logic pin,
  output logic      oe,
  output logic      out,
  output logic      got_valid,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // host pod: every slot is 21*m+1 clocks, m clocks per target cycle
  initial
  begin
    oe = 1'b0;
    out = 1'b0;
    got_valid = 1'b0;
    got = 8'h00;
  end

  task automatic strap(input logic v);
    oe <= ~v;
    out <= 1'b0;
  endtask

  task automatic slot(input int m, input int low);
    @(posedge clk);
    oe <= 1'b1;
    out <= 1'b0;
    repeat (low) @(posedge clk);
    out <= 1'b1;
    @(posedge clk);
    oe <= 1'b0;
    repeat (21 * m - low - 1) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] d, input int m, input int n);
    for (int i = 7; i > 7 - n; i--)
      slot(m, d[i] ? 4 * m : 15 * m);
  endtask

  task automatic recv(input int m);
    logic [7:0] b;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk);
      oe <= 1'b1;
      out <= 1'b0;
      repeat (3 * m + 2) @(posedge clk);
      oe <= 1'b0;
      repeat (7 * m - 2) @(posedge clk);
      b[i] = pin;
      repeat (11 * m) @(posedge clk);
    end
    got <= b;
    got_valid <= 1'b1;
    @(posedge clk);
    got_valid <= 1'b0;
  endtask
endmodule

/* bench/debug_single_wire_serial_port_test.sv */
module debug_single_wire_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // stimulus and wire
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       alt_clk_tick = 1'b0;
  logic       target_clock_select = 1'b0;
  logic       mode_b = 1'b0;
  logic       mode_a = 1'b0;
  logic       activate_cmd = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_load = 1'b0;
  logic       pin_out, pin_oe, pull_up_enable, mode_c, debug_active;
  logic       tx_busy, rx_valid, timeout, host_oe, host_out, got_valid, pin;
  logic [1:0] op_mode;
  logic [7:0] rx_data, got;
  logic [8:0] q[$];
  int         seed = 82289;
  int         checks = 0;
  int         n_fail = 0;
  int         gap = 0;
  logic       pin_q = 1'b1;

  // pull-up wins unless someone drives low
  assign pin = (pin_oe ? pin_out : 1'b1) & (host_oe ? host_out : 1'b1);
  always #2.5 clk = ~clk;
  always @(posedge clk) alt_clk_tick <= ~alt_clk_tick;

  // cycles since the last falling edge on the wire
  always @(posedge clk)
  begin
    pin_q <= pin;
    gap   <= (pin_q && !pin) ? 0 : gap + 1;
  end

  debug_single_wire_serial_port u_dut (.clk(clk), .reset(reset), .alt_clk_tick(alt_clk_tick),
    .target_clock_select(target_clock_select), .debug_serial_pin_in(pin),
    .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe),
    .pull_up_enable(pull_up_enable), .mode_select_b(mode_b), .mode_select_a(mode_a),
    .op_mode(op_mode), .mode_select_c(mode_c), .debug_active(debug_active),
    .activate_cmd(activate_cmd), .tx_data(tx_data), .tx_load(tx_load), .tx_busy(tx_busy),
    .rx_data(rx_data), .rx_valid(rx_valid), .timeout(timeout));
  dswsp_host u_host (.clk(clk), .pin(pin), .oe(host_oe), .out(host_out),
    .got_valid(got_valid), .got(got));

  // ==========================================
  // checking
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [8:0] note();
    if (q.size() == 0)
      return 9'h1FF;
    return q.pop_front();
  endfunction

  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      check({1'b0, rx_data}, note());
    if (timeout === 1'b1)
    begin
      check(9'h100, note());
      check({8'h00, gap >= 512 && gap <= 516}, 9'h001);
    end
    if (got_valid === 1'b1)
      check({1'b0, got}, note());
  end

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================
  // drivers
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction

  task automatic drain();
    for (int i = 0; i < 3000 && q.size() > 0; i++)
      @(posedge clk);
    if (q.size() > 0)
    begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic rst(input logic c, input logic b, input logic a);
    logic [1:0] m;
    m = c ? dswsp_pkg::MODE_NORMAL : ((b | a) ? dswsp_pkg::MODE_SPECIAL_OTHER
                                              : dswsp_pkg::MODE_SPECIAL_SINGLE);
    reset <= 1'b1;
    mode_b <= b;
    mode_a <= a;
    u_host.strap(c);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    u_host.strap(1'b1);
    @(posedge clk);
    #1;
    check({7'h00, op_mode}, {7'h00, m});
    check({8'h00, mode_c}, {8'h00, c});
    check({8'h00, debug_active}, {8'h00, ~(c | b | a)});
    check({8'h00, pull_up_enable}, 9'h001);
  endtask

  task automatic rx(input logic [7:0] d, input int m);
    q.push_back({1'b0, d});
    u_host.send(d, m, 8);
  endtask

  task automatic tx(input logic [7:0] d, input int m);
    @(posedge clk);
    tx_data <= d;
    tx_load <= 1'b1;
    @(posedge clk);
    tx_load <= 1'b0;
    #1;
    check({8'h00, tx_busy}, 9'h001);
    q.push_back({1'b0, d});
    u_host.recv(m);
  endtask

  // ==========================================
  // scenarios
  initial
  begin
    rst(1'b0, 1'b1, 1'b0);
    u_host.send(8'hA5, 1, 8);
    drain();
    @(posedge clk);
    activate_cmd <= 1'b1;
    @(posedge clk);
    activate_cmd <= 1'b0;
    #1;
    check({8'h00, debug_active}, 9'h001);
    rx(rnd(), 1);
    drain();
    rst(1'b1, 1'b0, 1'b0);
    rst(1'b0, 1'b0, 1'b1);
    rst(1'b0, 1'b0, 1'b0);
    tx(8'h81, 1);
    tx(rnd(), 1);
    rx(8'h01, 1);
    rx(8'hFE, 1);
    rx(rnd(), 1);
    drain();
    q.push_back(9'h100);
    u_host.send(rnd(), 1, 3);
    drain();
    rx(rnd(), 1);
    drain();
    target_clock_select <= 1'b1;
    tx(rnd(), 2);
    rx(rnd(), 2);
    drain();
    repeat (40) @(posedge clk);
    conclude();
  end
endmodule
